// *** sig_pkg.sv ***
package sig_pkg;
   // register byte offsets
   localparam logic [7:0] REG_CTRL0   = 8'h00;
   localparam logic [7:0] REG_CTRL4   = 8'h04;
   localparam logic [7:0] REG_FEAT    = 8'h08;
   localparam logic [7:0] REG_SIMDCSR = 8'h0C;
   localparam logic [7:0] REG_STATUS  = 8'h10;
   // control 0 bit positions
   localparam int CR0_MON_BIT  = 1;
   localparam int CR0_TRAP_BIT = 2;
   localparam int CR0_TSW_BIT  = 3;
   localparam int CR0_NERR_BIT = 5;
   localparam int CR0_AMSK_BIT = 18;
   // control 4 bit positions
   localparam int CR4_SAVE_BIT = 9;
   localparam int CR4_XMF_BIT  = 10;
   // feature register bit positions
   localparam int FEAT_BASE     = 0;
   localparam int FEAT_BASE2    = 1;
   localparam int FEAT_EXT3     = 2;
   localparam int FEAT_SUPP     = 3;
   localparam int FEAT_EXT41    = 4;
   localparam int FEAT_EXT42    = 5;
   localparam int FEAT_FLUSH    = 6;
   localparam int FEAT_BITCOUNT = 7;
   localparam int FEAT_SAVE     = 8;
   localparam int FEAT_W        = 9;
   // simd control/status fields
   localparam int CSR_MASK_LO = 7;
   localparam int CSR_NUM_EXC = 6;
   localparam int CSR_W       = 16;
   localparam logic [15:0] CSR_RESET  = 16'h0000;
   localparam logic [8:0]  FEAT_RESET = 9'h1FF;
   // status register bit positions
   localparam int STAT_PROT_WRITE = 4;
   localparam logic [1:0] PRIV_USER = 2'h3;
   // operand size codes
   localparam logic [1:0] SIZE_128 = 2'h3;
   // instruction classes seen by the gate
   typedef enum logic [3:0] {
      CLS_BASE_FP, CLS_BASE_INT, CLS_MEDIA64, CLS_UNALIGNED_MOVE,
      CLS_X87_TRUNC, CLS_EXEMPT, CLS_LINE_FLUSH, CLS_BIT_COUNT,
      CLS_CRC32, CLS_EXT4_FP, CLS_REDUCED
   } sig_insn_t;
   // fault answered for one instruction
   typedef enum logic [2:0] {
      FLT_NONE, FLT_INVALID_OPCODE, FLT_DEVICE_UNAVAILABLE,
      FLT_GENERAL_PROTECTION, FLT_ALIGNMENT_CHECK, FLT_SIMD_FP
   } sig_fault_t;
endpackage

// *** sig_align.sv ***
`timescale 1ns/100ps
module sig_align (
   // operand
   input  wire logic [1:0] size_i,
   input  wire logic [3:0] addr_lo_i,
   // result
   output logic            misaligned_o
);
   // size code n means an operand of 2**(n+1) bytes
   always_comb begin
      case (size_i)
         2'h0:    misaligned_o = addr_lo_i[0];
         2'h1:    misaligned_o = |addr_lo_i[1:0];
         2'h2:    misaligned_o = |addr_lo_i[2:0];
         default: misaligned_o = |addr_lo_i;
      endcase
   end
endmodule

// *** sig_gate.sv ***
`timescale 1ns/100ps
module sig_gate (
   // clock and reset
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   // wishbone slave
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   input  wire logic                  wb_we_i,
   input  wire logic [7:0]            wb_adr_i,
   input  wire logic [3:0]            wb_sel_i,
   input  wire logic [31:0]           wb_dat_i,
   output logic      [31:0]           wb_dat_o,
   output logic                       wb_ack_o,
   // instruction check request
   input  wire logic                  chk_valid_i,
   input  wire sig_pkg::sig_insn_t    chk_class_i,
   input  wire logic [2:0]            chk_feat_sel_i,
   input  wire logic                  chk_mem_i,
   input  wire logic                  chk_stack_i,
   input  wire logic [1:0]            chk_size_i,
   input  wire logic [3:0]            chk_addr_lo_i,
   input  wire logic [1:0]            chk_priv_i,
   input  wire logic                  chk_flags_align_i,
   input  wire logic [5:0]            chk_num_exc_i,
   // instruction check answer
   output logic                       rsp_valid_o,
   output sig_pkg::sig_fault_t        rsp_fault_o,
   output logic                       rsp_commit_o,
   output logic                       rsp_subst_o,
   // write of state save enable refused
   output logic                       wr_fault_o
);
   typedef struct packed {
      logic                 ack;
      logic [31:0]          rdata;
      logic                 mon;
      logic                 trap;
      logic                 tsw;
      logic                 nerr;
      logic                 amsk;
      logic                 os_save;
      logic                 os_xmf;
      logic [8:0]           feat;
      logic [15:0]          csr;
      logic                 prot_wr;
      logic                 wr_fault;
      logic                 rsp_valid;
      sig_pkg::sig_fault_t  fault;
      logic                 subst;
      sig_pkg::sig_fault_t  last_fault;
   } sig_state_t;

   sig_state_t st_q;
   sig_state_t st_d;

   logic       misaligned;
   logic       sel_feat;
   logic       wide;
   logic       fp_op;
   logic [5:0] unmasked;
   logic [5:0] masked;
   logic [31:0] wmask;
   logic [31:0] wval;
   logic       acc;
   sig_pkg::sig_fault_t chk_fault;

   sig_align u_align (
      .size_i       (chk_size_i),
      .addr_lo_i    (chk_addr_lo_i),
      .misaligned_o (misaligned)
   );

   assign sel_feat = st_q.feat[chk_feat_sel_i];
   assign wide     = chk_mem_i && (chk_size_i == sig_pkg::SIZE_128);
   assign fp_op    = (chk_class_i == sig_pkg::CLS_BASE_FP) ||
                     (chk_class_i == sig_pkg::CLS_EXT4_FP);
   assign unmasked = fp_op ? chk_num_exc_i & ~st_q.csr[12:7] : 6'h00;
   assign masked   = fp_op ? chk_num_exc_i & st_q.csr[12:7] : 6'h00;
   assign wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign acc      = wb_cyc_i && wb_stb_i && !st_q.ack;

   // fault priority: invalid opcode, device, memory, numeric
   always_comb begin
      chk_fault = sig_pkg::FLT_NONE;
      case (chk_class_i)
         sig_pkg::CLS_EXEMPT: begin
            chk_fault = sig_pkg::FLT_NONE;
         end
         sig_pkg::CLS_LINE_FLUSH: begin
            if (!st_q.feat[sig_pkg::FEAT_FLUSH])
               chk_fault = sig_pkg::FLT_INVALID_OPCODE;
         end
         sig_pkg::CLS_BIT_COUNT: begin
            if (!st_q.feat[sig_pkg::FEAT_BITCOUNT])
               chk_fault = sig_pkg::FLT_INVALID_OPCODE;
         end
         sig_pkg::CLS_CRC32: begin
            if (!sel_feat)
               chk_fault = sig_pkg::FLT_INVALID_OPCODE;
         end
         sig_pkg::CLS_X87_TRUNC: begin
            if (!sel_feat || st_q.trap)
               chk_fault = sig_pkg::FLT_INVALID_OPCODE;
            else if (st_q.tsw)
               chk_fault = sig_pkg::FLT_DEVICE_UNAVAILABLE;
         end
         sig_pkg::CLS_MEDIA64: begin
            if (!sel_feat || st_q.trap)
               chk_fault = sig_pkg::FLT_INVALID_OPCODE;
            else if (st_q.tsw)
               chk_fault = sig_pkg::FLT_DEVICE_UNAVAILABLE;
         end
         default: begin
            if (!st_q.os_save)
               chk_fault = sig_pkg::FLT_INVALID_OPCODE;
            else if (!sel_feat)
               chk_fault = sig_pkg::FLT_INVALID_OPCODE;
            else if (st_q.trap)
               chk_fault = sig_pkg::FLT_INVALID_OPCODE;
            else if (st_q.tsw)
               chk_fault = sig_pkg::FLT_DEVICE_UNAVAILABLE;
         end
      endcase
      if (chk_fault == sig_pkg::FLT_NONE && chk_class_i != sig_pkg::CLS_EXEMPT) begin
         // stack segment wide misalignment takes the same fault
         if (wide && misaligned && chk_class_i != sig_pkg::CLS_UNALIGNED_MOVE)
            chk_fault = sig_pkg::FLT_GENERAL_PROTECTION;
         else if (chk_mem_i && !wide && misaligned && st_q.amsk && chk_flags_align_i &&
                  chk_priv_i == sig_pkg::PRIV_USER)
            chk_fault = sig_pkg::FLT_ALIGNMENT_CHECK;
         else if (|unmasked && chk_class_i != sig_pkg::CLS_REDUCED)
            // numeric error report flag never consulted
            chk_fault = st_q.os_xmf ? sig_pkg::FLT_SIMD_FP
                                    : sig_pkg::FLT_INVALID_OPCODE;
      end
   end

   always_comb begin
      st_d = st_q;
      st_d.ack = acc;
      st_d.wr_fault = 1'b0;
      st_d.rsp_valid = chk_valid_i;
      st_d.fault = chk_valid_i ? chk_fault : sig_pkg::FLT_NONE;
      st_d.subst = chk_valid_i && chk_fault == sig_pkg::FLT_NONE && |masked;
      if (chk_valid_i && chk_fault != sig_pkg::FLT_NONE)
         st_d.last_fault = chk_fault;
      wval = 32'h0000_0000;
      if (acc && wb_we_i) begin
         if (wb_adr_i == sig_pkg::REG_CTRL0) begin
            wval = (wb_dat_i & wmask) | ({13'h0000, st_q.amsk, 12'h000, st_q.nerr, 1'b0,
                   st_q.tsw, st_q.trap, st_q.mon, 1'b0} & ~wmask);
            st_d.mon  = wval[sig_pkg::CR0_MON_BIT];
            st_d.trap = wval[sig_pkg::CR0_TRAP_BIT];
            st_d.tsw  = wval[sig_pkg::CR0_TSW_BIT];
            st_d.nerr = wval[sig_pkg::CR0_NERR_BIT];
            st_d.amsk = wval[sig_pkg::CR0_AMSK_BIT];
         end else if (wb_adr_i == sig_pkg::REG_CTRL4) begin
            wval = (wb_dat_i & wmask) | ({21'h00_0000, st_q.os_xmf, st_q.os_save,
                   9'h000} & ~wmask);
            st_d.os_xmf = wval[sig_pkg::CR4_XMF_BIT];
            if (wval[sig_pkg::CR4_SAVE_BIT] && !st_q.feat[sig_pkg::FEAT_SAVE]) begin
               st_d.wr_fault = 1'b1;
               st_d.prot_wr = 1'b1;
            end else begin
               st_d.os_save = wval[sig_pkg::CR4_SAVE_BIT];
            end
         end else if (wb_adr_i == sig_pkg::REG_FEAT) begin
            wval = (wb_dat_i & wmask) | ({23'h00_0000, st_q.feat} & ~wmask);
            st_d.feat = wval[8:0];
         end else if (wb_adr_i == sig_pkg::REG_SIMDCSR) begin
            wval = (wb_dat_i & wmask) | ({16'h0000, st_q.csr} & ~wmask);
            st_d.csr = wval[15:0];
         end else if (wb_adr_i == sig_pkg::REG_STATUS) begin
            // set comes only from a control 4 write, so it never meets this clear
            if (wb_sel_i[0] && wb_dat_i[sig_pkg::STAT_PROT_WRITE])
               st_d.prot_wr = 1'b0;
         end
      end
      // simd numeric flags stick; a new event wins over a clear
      if (chk_valid_i && fp_op && chk_fault != sig_pkg::FLT_GENERAL_PROTECTION &&
          chk_fault != sig_pkg::FLT_ALIGNMENT_CHECK)
         st_d.csr[5:0] = st_d.csr[5:0] | masked | unmasked;
      st_d.rdata = 32'h0000_0000;
      if (acc && !wb_we_i) begin
         if (wb_adr_i == sig_pkg::REG_CTRL0)
            st_d.rdata = {13'h0000, st_q.amsk, 12'h000, st_q.nerr, 1'b0,
                          st_q.tsw, st_q.trap, st_q.mon, 1'b0};
         else if (wb_adr_i == sig_pkg::REG_CTRL4)
            st_d.rdata = {21'h00_0000, st_q.os_xmf, st_q.os_save, 9'h000};
         else if (wb_adr_i == sig_pkg::REG_FEAT)
            st_d.rdata = {23'h00_0000, st_q.feat};
         else if (wb_adr_i == sig_pkg::REG_SIMDCSR)
            st_d.rdata = {16'h0000, st_q.csr};
         else if (wb_adr_i == sig_pkg::REG_STATUS)
            st_d.rdata = {27'h000_0000, st_q.prot_wr, 1'b0, st_q.last_fault};
      end
      if (rst_i) begin
         st_d = '0;
         st_d.feat = sig_pkg::FEAT_RESET;
         st_d.csr = sig_pkg::CSR_RESET;
      end
   end

   always_ff @(posedge clk_i) begin
      st_q <= st_d;
   end

   assign wb_ack_o     = st_q.ack;
   assign wb_dat_o     = st_q.rdata;
   assign rsp_valid_o  = st_q.rsp_valid;
   assign rsp_fault_o  = st_q.fault;
   assign rsp_commit_o = st_q.rsp_valid && st_q.fault == sig_pkg::FLT_NONE;
   assign rsp_subst_o  = st_q.subst;
   assign wr_fault_o   = st_q.wr_fault;

   sequence s_full_enable;
      chk_valid_i && chk_class_i == sig_pkg::CLS_BASE_FP && st_q.os_save && st_q.os_xmf
      && sel_feat && !st_q.trap && !st_q.tsw && !chk_mem_i;
   endsequence
   sequence s_unmasked_err;
      |(chk_num_exc_i & ~st_q.csr[12:7]);
   endsequence

   AST_FULL_XMF: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_full_enable and s_unmasked_err) |=> rsp_fault_o == sig_pkg::FLT_SIMD_FP)
      else $error("unmasked error in full enable did not give simd fault");
   AST_TASK_DEV: assert property (@(posedge clk_i) disable iff (rst_i)
      chk_valid_i && chk_class_i == sig_pkg::CLS_BASE_INT && st_q.os_save && sel_feat
      && !st_q.trap && st_q.tsw |=> rsp_fault_o == sig_pkg::FLT_DEVICE_UNAVAILABLE)
      else $error("task switched did not give device unavailable");
   AST_TRAP_INV: assert property (@(posedge clk_i) disable iff (rst_i)
      chk_valid_i && chk_class_i == sig_pkg::CLS_REDUCED && st_q.trap
      |=> rsp_fault_o == sig_pkg::FLT_INVALID_OPCODE && !rsp_commit_o)
      else $error("soft trap flag did not give invalid opcode");
   AST_SAVE_INV: assert property (@(posedge clk_i) disable iff (rst_i)
      chk_valid_i && chk_class_i == sig_pkg::CLS_BASE_FP && !st_q.os_save
      |=> rsp_fault_o == sig_pkg::FLT_INVALID_OPCODE)
      else $error("state save disabled did not give invalid opcode");
   AST_NOHANDLER_INV: assert property (@(posedge clk_i) disable iff (rst_i)
      chk_valid_i && fp_op && st_q.os_save && sel_feat && !st_q.trap && !st_q.tsw
      && !chk_mem_i && |unmasked && !st_q.os_xmf
      |=> rsp_fault_o == sig_pkg::FLT_INVALID_OPCODE)
      else $error("missing handler enable did not give invalid opcode");
   AST_FLUSH_ONLY: assert property (@(posedge clk_i) disable iff (rst_i)
      chk_valid_i && chk_class_i == sig_pkg::CLS_LINE_FLUSH && !chk_mem_i
      |=> rsp_commit_o == $past(st_q.feat[sig_pkg::FEAT_FLUSH]))
      else $error("line flush gating wrong");
   AST_WIDE_PROT: assert property (@(posedge clk_i) disable iff (rst_i)
      chk_valid_i && chk_class_i == sig_pkg::CLS_BASE_INT && st_q.os_save && sel_feat
      && !st_q.trap && !st_q.tsw && wide && |chk_addr_lo_i
      |=> rsp_fault_o == sig_pkg::FLT_GENERAL_PROTECTION)
      else $error("wide misaligned access did not fault");
   AST_STACK_PROT: assert property (@(posedge clk_i) disable iff (rst_i)
      chk_valid_i && chk_stack_i && chk_class_i == sig_pkg::CLS_BASE_FP && st_q.os_save
      && sel_feat && !st_q.trap && !st_q.tsw && wide && |chk_addr_lo_i
      |=> rsp_fault_o == sig_pkg::FLT_GENERAL_PROTECTION)
      else $error("stack wide misaligned access did not give protection fault");
   AST_UMOVE_OK: assert property (@(posedge clk_i) disable iff (rst_i)
      chk_valid_i && chk_class_i == sig_pkg::CLS_UNALIGNED_MOVE && wide
      |=> rsp_fault_o != sig_pkg::FLT_GENERAL_PROTECTION)
      else $error("unaligned move faulted on wide access");
   AST_ALIGN_GATE: assert property (@(posedge clk_i) disable iff (rst_i)
      rsp_fault_o == sig_pkg::FLT_ALIGNMENT_CHECK
      |-> $past(st_q.amsk && chk_flags_align_i && chk_priv_i == sig_pkg::PRIV_USER))
      else $error("alignment check without enables");
   AST_INT_NONUM: assert property (@(posedge clk_i) disable iff (rst_i)
      chk_valid_i && chk_class_i == sig_pkg::CLS_BASE_INT
      |=> rsp_fault_o != sig_pkg::FLT_SIMD_FP && !rsp_subst_o)
      else $error("integer operation raised numeric error");
   AST_WR_PROT: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_fault_o |-> $stable(st_q.os_save) && st_q.prot_wr ##1 wb_ack_o == 1'b0)
      else $error("refused save enable write changed state");
   AST_ONE_RSP: assert property (@(posedge clk_i) disable iff (rst_i)
      rsp_valid_o && rsp_fault_o != sig_pkg::FLT_NONE |-> !rsp_commit_o && !rsp_subst_o)
      else $error("faulting instruction committed");
endmodule

// *** sig_pipe_model.sv ***
`timescale 1ns/100ps
module sig_pipe_model (
   // clock
   input  wire logic                clk_i,
   // check request
   output logic                     chk_valid_o,
   output sig_pkg::sig_insn_t       chk_class_o,
   output logic [2:0]               chk_feat_sel_o,
   output logic                     chk_mem_o,
   output logic                     chk_stack_o,
   output logic [1:0]               chk_size_o,
   output logic [3:0]               chk_addr_lo_o,
   output logic [1:0]               chk_priv_o,
   output logic                     chk_flags_align_o,
   output logic [5:0]               chk_num_exc_o,
   // check answer
   input  wire logic                rsp_valid_i,
   input  wire sig_pkg::sig_fault_t rsp_fault_i,
   input  wire logic                rsp_commit_i,
   input  wire logic                rsp_subst_i
);
   initial begin
      chk_valid_o    = 1'h0;
      chk_class_o    = sig_pkg::CLS_EXEMPT;
      chk_feat_sel_o = 3'h0;
      {chk_mem_o, chk_stack_o, chk_size_o, chk_priv_o, chk_flags_align_o} = 7'h00;
      chk_addr_lo_o  = 4'h0;
      chk_num_exc_o  = 6'h00;
   end

   // m packs mem, stack, size, priv, flags align, addr low; r packs valid, subst, commit, fault
   task automatic issue(input sig_pkg::sig_insn_t c, input logic [2:0] f,
                        input logic [10:0] m, input logic [5:0] e, output logic [5:0] r);
      @(posedge clk_i);
      chk_valid_o    <= 1'h1;
      chk_class_o    <= c;
      chk_feat_sel_o <= f;
      {chk_mem_o, chk_stack_o, chk_size_o, chk_priv_o, chk_flags_align_o, chk_addr_lo_o} <= m;
      chk_num_exc_o  <= e;
      @(posedge clk_i);
      // released address, size and exception fields stop showing the last value
      chk_valid_o    <= 1'h0;
      chk_addr_lo_o  <= ~chk_addr_lo_o;
      chk_size_o     <= ~chk_size_o;
      chk_num_exc_o  <= ~e;
      @(negedge clk_i);
      r = {rsp_valid_i, rsp_subst_i, rsp_commit_i, rsp_fault_i};
   endtask
endmodule

// *** sig_gate_bench.sv ***
`timescale 1ns/100ps
module sig_gate_bench;
   logic                clk_i     = 1'h0;
   logic                rst_i     = 1'h1;
   logic                wb_cyc_i  = 1'h0;
   logic                wb_stb_i  = 1'h0;
   logic                wb_we_i   = 1'h0;
   logic [7:0]          wb_adr_i  = 8'h00;
   logic [3:0]          wb_sel_i  = 4'h0;
   logic [31:0]         wb_dat_i  = 32'h0000_0000;
   logic [31:0]         wb_dat_o;
   logic                wb_ack_o;
   logic                chk_valid, chk_mem, chk_stack, chk_align;
   sig_pkg::sig_insn_t  chk_class;
   logic [2:0]          chk_sel;
   logic [1:0]          chk_size, chk_priv;
   logic [3:0]          chk_addr;
   logic [5:0]          chk_exc;
   logic                rsp_valid, rsp_commit, rsp_subst, wr_fault_o;
   sig_pkg::sig_fault_t rsp_fault;
   logic [10:0]         mv        = 11'h000;
   logic [31:0]         q;
   int                  error_cnt = 0;
   int                  tests_run = 0;
   int                  wf_cnt    = 0;

   always #25 clk_i = ~clk_i;
   always @(posedge clk_i) if (wr_fault_o === 1'h1) wf_cnt++;

   sig_gate u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .chk_valid_i(chk_valid),
      .chk_class_i(chk_class), .chk_feat_sel_i(chk_sel), .chk_mem_i(chk_mem),
      .chk_stack_i(chk_stack), .chk_size_i(chk_size), .chk_addr_lo_i(chk_addr),
      .chk_priv_i(chk_priv), .chk_flags_align_i(chk_align), .chk_num_exc_i(chk_exc),
      .rsp_valid_o(rsp_valid), .rsp_fault_o(rsp_fault), .rsp_commit_o(rsp_commit),
      .rsp_subst_o(rsp_subst), .wr_fault_o(wr_fault_o));

   sig_pipe_model u_pipe (.clk_i(clk_i), .chk_valid_o(chk_valid), .chk_class_o(chk_class),
      .chk_feat_sel_o(chk_sel), .chk_mem_o(chk_mem), .chk_stack_o(chk_stack),
      .chk_size_o(chk_size), .chk_addr_lo_o(chk_addr), .chk_priv_o(chk_priv),
      .chk_flags_align_o(chk_align), .chk_num_exc_o(chk_exc), .rsp_valid_i(rsp_valid),
      .rsp_fault_i(rsp_fault), .rsp_commit_i(rsp_commit), .rsp_subst_i(rsp_subst));

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_sel_i <= 4'hF;
      wb_dat_i <= d;
      // only the acknowledge or the watchdog ends a wait for the answer
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'h1);
      q = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'h1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      xfer(1'h0, a, 32'h0000_0000);
      check(q, e);
   endtask

   task automatic go(input sig_pkg::sig_insn_t c, input logic [2:0] f, input logic [5:0] e,
                     input sig_pkg::sig_fault_t x, input logic s);
      logic [5:0] r;
      u_pipe.issue(c, f, mv, e, r);
      check(32'(r), 32'({1'h1, s, x == sig_pkg::FLT_NONE, x}));
   endtask

   initial begin
      repeat (20000) @(posedge clk_i);
      error_cnt++;
      test_done;
   end

   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'h0;
      rd(sig_pkg::REG_CTRL0, 32'h0000_0000);
      rd(sig_pkg::REG_CTRL4, 32'h0000_0000);
      rd(sig_pkg::REG_FEAT, 32'h0000_01FF);
      rd(sig_pkg::REG_SIMDCSR, 32'h0000_0000);
      rd(sig_pkg::REG_STATUS, 32'h0000_0000);
      wr(8'h20, 32'h0000_FFFF);
      rd(8'h20, 32'h0000_0000);
      $display("test registers done");
      wr(sig_pkg::REG_CTRL0, 32'h0000_0002);
      wr(sig_pkg::REG_SIMDCSR, 32'h0000_0000);
      wr(sig_pkg::REG_CTRL4, 32'h0000_0600);
      go(sig_pkg::CLS_BASE_FP, 3'h0, 6'h00, sig_pkg::FLT_NONE, 1'h0);
      go(sig_pkg::CLS_BASE_FP, 3'h0, 6'h01, sig_pkg::FLT_SIMD_FP, 1'h0);
      go(sig_pkg::CLS_BASE_INT, 3'h0, 6'h3F, sig_pkg::FLT_NONE, 1'h0);
      go(sig_pkg::CLS_EXT4_FP, 3'h4, 6'h01, sig_pkg::FLT_SIMD_FP, 1'h0);
      wr(sig_pkg::REG_CTRL0, 32'h0000_0022);
      go(sig_pkg::CLS_BASE_FP, 3'h0, 6'h20, sig_pkg::FLT_SIMD_FP, 1'h0);
      wr(sig_pkg::REG_SIMDCSR, 32'h0000_1F80);
      go(sig_pkg::CLS_BASE_FP, 3'h0, 6'h02, sig_pkg::FLT_NONE, 1'h1);
      wr(sig_pkg::REG_SIMDCSR, 32'h0000_0000);
      $display("test numeric done");
      wr(sig_pkg::REG_CTRL0, 32'h0000_000A);
      go(sig_pkg::CLS_BASE_FP, 3'h0, 6'h00, sig_pkg::FLT_DEVICE_UNAVAILABLE, 1'h0);
      go(sig_pkg::CLS_REDUCED, 3'h3, 6'h00, sig_pkg::FLT_DEVICE_UNAVAILABLE, 1'h0);
      go(sig_pkg::CLS_EXEMPT, 3'h0, 6'h00, sig_pkg::FLT_NONE, 1'h0);
      wr(sig_pkg::REG_CTRL0, 32'h0000_000E);
      go(sig_pkg::CLS_BASE_FP, 3'h0, 6'h00, sig_pkg::FLT_INVALID_OPCODE, 1'h0);
      go(sig_pkg::CLS_BIT_COUNT, 3'h0, 6'h00, sig_pkg::FLT_NONE, 1'h0);
      go(sig_pkg::CLS_CRC32, 3'h5, 6'h00, sig_pkg::FLT_NONE, 1'h0);
      wr(sig_pkg::REG_CTRL0, 32'h0000_0002);
      wr(sig_pkg::REG_CTRL4, 32'h0000_0400);
      go(sig_pkg::CLS_REDUCED, 3'h3, 6'h00, sig_pkg::FLT_INVALID_OPCODE, 1'h0);
      go(sig_pkg::CLS_MEDIA64, 3'h0, 6'h00, sig_pkg::FLT_NONE, 1'h0);
      go(sig_pkg::CLS_X87_TRUNC, 3'h0, 6'h00, sig_pkg::FLT_NONE, 1'h0);
      wr(sig_pkg::REG_CTRL4, 32'h0000_0200);
      go(sig_pkg::CLS_BASE_FP, 3'h0, 6'h01, sig_pkg::FLT_INVALID_OPCODE, 1'h0);
      wr(sig_pkg::REG_CTRL4, 32'h0000_0600);
      wr(sig_pkg::REG_FEAT, 32'h0000_01FE);
      go(sig_pkg::CLS_BASE_FP, 3'h0, 6'h00, sig_pkg::FLT_INVALID_OPCODE, 1'h0);
      go(sig_pkg::CLS_LINE_FLUSH, 3'h0, 6'h00, sig_pkg::FLT_NONE, 1'h0);
      wr(sig_pkg::REG_FEAT, 32'h0000_013F);
      go(sig_pkg::CLS_LINE_FLUSH, 3'h0, 6'h00, sig_pkg::FLT_INVALID_OPCODE, 1'h0);
      go(sig_pkg::CLS_BIT_COUNT, 3'h0, 6'h00, sig_pkg::FLT_INVALID_OPCODE, 1'h0);
      go(sig_pkg::CLS_BASE_FP, 3'h0, 6'h00, sig_pkg::FLT_NONE, 1'h0);
      wr(sig_pkg::REG_FEAT, 32'h0000_01FF);
      $display("test gating done");
      mv = {1'h1, 1'h0, sig_pkg::SIZE_128, 2'h0, 1'h0, 4'h4};
      go(sig_pkg::CLS_BASE_FP, 3'h0, 6'h00, sig_pkg::FLT_GENERAL_PROTECTION, 1'h0);
      go(sig_pkg::CLS_UNALIGNED_MOVE, 3'h0, 6'h00, sig_pkg::FLT_NONE, 1'h0);
      mv = {1'h1, 1'h1, sig_pkg::SIZE_128, 2'h0, 1'h0, 4'h8};
      go(sig_pkg::CLS_BASE_FP, 3'h0, 6'h00, sig_pkg::FLT_GENERAL_PROTECTION, 1'h0);
      wr(sig_pkg::REG_CTRL0, 32'h0004_0002);
      mv = {1'h1, 1'h0, 2'h1, sig_pkg::PRIV_USER, 1'h1, 4'h1};
      go(sig_pkg::CLS_BASE_FP, 3'h0, 6'h00, sig_pkg::FLT_ALIGNMENT_CHECK, 1'h0);
      mv = {1'h1, 1'h0, 2'h2, sig_pkg::PRIV_USER, 1'h1, 4'h2};
      go(sig_pkg::CLS_UNALIGNED_MOVE, 3'h0, 6'h00, sig_pkg::FLT_ALIGNMENT_CHECK, 1'h0);
      mv = {1'h1, 1'h0, sig_pkg::SIZE_128, sig_pkg::PRIV_USER, 1'h1, 4'h4};
      go(sig_pkg::CLS_UNALIGNED_MOVE, 3'h0, 6'h00, sig_pkg::FLT_NONE, 1'h0);
      mv = {1'h1, 1'h0, 2'h1, 2'h0, 1'h1, 4'h1};
      go(sig_pkg::CLS_BASE_FP, 3'h0, 6'h00, sig_pkg::FLT_NONE, 1'h0);
      mv = {1'h1, 1'h0, 2'h1, sig_pkg::PRIV_USER, 1'h0, 4'h1};
      go(sig_pkg::CLS_BASE_FP, 3'h0, 6'h00, sig_pkg::FLT_NONE, 1'h0);
      mv = 11'h000;
      $display("test alignment done");
      wr(sig_pkg::REG_CTRL4, 32'h0000_0000);
      wr(sig_pkg::REG_FEAT, 32'h0000_00FF);
      wr(sig_pkg::REG_CTRL4, 32'h0000_0600);
      rd(sig_pkg::REG_CTRL4, 32'h0000_0400);
      check(32'(wf_cnt), 32'h0000_0001);
      xfer(1'h0, sig_pkg::REG_STATUS, 32'h0000_0000);
      check(q & 32'h0000_0010, 32'h0000_0010);
      wr(sig_pkg::REG_STATUS, 32'h0000_0010);
      xfer(1'h0, sig_pkg::REG_STATUS, 32'h0000_0000);
      check(q & 32'h0000_0010, 32'h0000_0000);
      $display("test refused write done");
      test_done;
   end
endmodule
